// file: rtl/flash_bus_cycle.sv
// one asynchronous flash bus cycle, read or write, from the host side
`timescale 1ns/10ps
module flash_bus_cycle (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [20:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata,
  output logic [20:0]      flash_addr,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [15:0] flash_dq_in
);

  typedef enum logic [1:0] {cyc_idle, cyc_setup, cyc_strobe, cyc_hold} cyc_state_type;

  typedef struct packed {
    cyc_state_type state;
    logic [3:0]    count;
    logic          write;
    logic          done;
    logic [20:0]   addr;
    logic [15:0]   wdata;
    logic [15:0]   rdata;
    logic          ce_n;
    logic          we_n;
    logic          oe_n;
    logic          dq_oe_n;
    logic [15:0]   dq_meta;
    logic [15:0]   dq_sync;
  } cyc_regs_type;

  cyc_regs_type r;
  cyc_regs_type next_r;

  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    // data lines pass two flops before anything reads them
    next_r.dq_meta = flash_dq_in;
    next_r.dq_sync = r.dq_meta;
    case (r.state)
      cyc_idle: begin
        if (start) begin
          next_r.state = cyc_setup;
          next_r.count = flash_query_pkg::setup_cycles;
          next_r.write = is_write;
          next_r.addr = addr;
          next_r.wdata = wdata;
          next_r.ce_n = 1'b0;
          next_r.dq_oe_n = ~is_write;
        end
      end
      cyc_setup: begin
        next_r.count = r.count - 4'h1;
        if (r.count == 4'h1) begin
          next_r.state = cyc_strobe;
          // addr settled early: address stable before the later falling strobe
          if (r.write) begin
            next_r.we_n = 1'b0;
            next_r.count = flash_query_pkg::strobe_cycles;
          end else begin
            next_r.oe_n = 1'b0;
            next_r.count = flash_query_pkg::read_cycles;
          end
        end
      end
      cyc_strobe: begin
        next_r.count = r.count - 4'h1;
        if (r.count == 4'h1) begin
          next_r.state = cyc_hold;
          next_r.count = flash_query_pkg::hold_cycles;
          // data latch edge: we rises first, ce stays low one hold period
          next_r.we_n = 1'b1;
          next_r.oe_n = 1'b1;
          if (!r.write) begin
            next_r.rdata = r.dq_sync;
          end
        end
      end
      cyc_hold: begin
        next_r.count = r.count - 4'h1;
        next_r.ce_n = 1'b1;
        if (r.count == 4'h1) begin
          // data released on the same edge that ce goes high again
          next_r.dq_oe_n = 1'b1;
          next_r.state = cyc_idle;
          next_r.done = 1'b1;
        end
      end
      default: next_r.state = cyc_idle;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.state <= cyc_idle;
      r.count <= 4'h0;
      r.write <= 1'b0;
      r.done <= 1'b0;
      r.addr <= 21'h000000;
      r.wdata <= 16'h0000;
      r.rdata <= 16'h0000;
      r.ce_n <= 1'b1;
      r.we_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.dq_oe_n <= 1'b1;
      r.dq_meta <= 16'h0000;
      r.dq_sync <= 16'h0000;
    end else begin
      r <= next_r;
    end
  end

  assign done          = r.done;
  assign rdata         = r.rdata;
  assign flash_addr    = r.addr;
  assign flash_ce_n    = r.ce_n;
  assign flash_we_n    = r.we_n;
  assign flash_oe_n    = r.oe_n;
  assign flash_dq_out  = r.wdata;
  assign flash_dq_oe_n = r.dq_oe_n;

endmodule : flash_bus_cycle

// file: rtl/flash_query_host.sv
// host controller that drives flash query mode from register commands
//
// Contract
// - query command 98h at 55h/AAh enters query
// - only the reset command leaves query mode
// - address latched on later falling strobe
// - data latched on first rising strobe
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module flash_query_host #(
  parameter logic [15:0] reset_cmd = flash_query_pkg::reset_cmd_default
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [20:0]      flash_addr,
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic             flash_word_mode,
  output logic [15:0]      flash_dq_out,
  output logic             flash_dq_oe_n,
  input  wire logic [15:0] flash_dq_in,
  input  wire logic        flash_ready
);

  typedef enum logic [1:0] {op_idle, op_wait_ready, op_run} op_state_type;

  typedef struct packed {
    logic         aw_held;
    logic [7:0]   aw_addr;
    logic         w_held;
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [1:0]   rresp;
    logic [31:0]  rdata;
    logic [1:0]   op;
    logic         byte_mode;
    logic [19:0]  addr;
    logic [15:0]  wdata;
    logic [15:0]  rdata_flash;
    logic         in_query;
    logic [2:0]   sig_seen;
    logic         refused;
    op_state_type state;
    logic         cyc_start;
    logic         ready_meta;
    logic         ready_sync;
  } host_regs_type;

  host_regs_type r;
  host_regs_type next_r;

  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic [20:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic        cyc_write;

  // address and data driven to the flash for the pending operation
  always_comb begin
    cyc_addr = {1'b0, r.addr};
    cyc_wdata = r.wdata;
    cyc_write = 1'b1;
    case (r.op)
      flash_query_pkg::op_enter_query: begin
        // query entry: word or byte command address
        cyc_addr = r.byte_mode ? flash_query_pkg::query_byte_addr
                               : flash_query_pkg::query_word_addr;
        cyc_wdata = flash_query_pkg::query_cmd;
      end
      flash_query_pkg::op_exit_query: begin
        // reset command: address is a don't care
        cyc_addr = 21'h000000;
        cyc_wdata = reset_cmd;
      end
      flash_query_pkg::op_read: begin
        // byte addressing: table word n sits at byte 2n
        cyc_addr = r.byte_mode ? {r.addr, 1'b0} : {1'b0, r.addr};
        cyc_write = 1'b0;
      end
      default: begin
        cyc_write = 1'b1;
      end
    endcase
  end

  always_comb begin
    logic [31:0] status_word;
    logic        go;
    logic        wr_fire;
    status_word = 32'h00000000;
    go = 1'b0;
    wr_fire = 1'b0;
    next_r = r;
    next_r.cyc_start = 1'b0;
    // ready pin passes two flops before it is looked at
    next_r.ready_meta = flash_ready;
    next_r.ready_sync = r.ready_meta;

    status_word[flash_query_pkg::status_busy_bit]    = (r.state != op_idle);
    status_word[flash_query_pkg::status_query_bit]   = r.in_query;
    status_word[flash_query_pkg::status_sig_bit]     = &r.sig_seen;
    status_word[flash_query_pkg::status_refused_bit] = r.refused;
    status_word[flash_query_pkg::status_ready_bit]   = r.ready_sync;

    // write address and data are taken in either order
    if (s_axi_awvalid && !r.aw_held) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.w_held) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.aw_held && r.w_held && !r.bvalid) begin
      wr_fire = 1'b1;
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = flash_query_pkg::resp_okay;
      if (r.aw_addr == flash_query_pkg::ctrl_offset) begin
        if (r.w_strb[0]) begin
          go = r.w_data[flash_query_pkg::ctrl_go_bit];
          if (r.state == op_idle) begin
            next_r.byte_mode = r.w_data[flash_query_pkg::ctrl_byte_mode_bit];
            next_r.op = r.w_data[flash_query_pkg::ctrl_op_lsb +: 2];
          end
        end
      end else if (r.aw_addr == flash_query_pkg::addr_offset) begin
        if (r.w_strb[0]) next_r.addr[7:0] = r.w_data[7:0];
        if (r.w_strb[1]) next_r.addr[15:8] = r.w_data[15:8];
        if (r.w_strb[2]) next_r.addr[19:16] = r.w_data[19:16];
      end else if (r.aw_addr == flash_query_pkg::wdata_offset) begin
        if (r.w_strb[0]) next_r.wdata[7:0] = r.w_data[7:0];
        if (r.w_strb[1]) next_r.wdata[15:8] = r.w_data[15:8];
      end else if (r.aw_addr == flash_query_pkg::status_offset) begin
        // write one to clear; a refusal in the same cycle wins below
        if (r.w_strb[0] && r.w_data[flash_query_pkg::status_refused_bit]) begin
          next_r.refused = 1'b0;
        end
      end else if (r.aw_addr != flash_query_pkg::rdata_offset) begin
        next_r.bresp = flash_query_pkg::resp_slverr;
      end
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end

    // read channel: answer one cycle after the address is taken
    if (s_axi_arvalid && !r.rvalid) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = flash_query_pkg::resp_okay;
      next_r.rdata = 32'h00000000;
      if (s_axi_araddr == flash_query_pkg::ctrl_offset) begin
        next_r.rdata[flash_query_pkg::ctrl_op_lsb +: 2] = r.op;
        next_r.rdata[flash_query_pkg::ctrl_byte_mode_bit] = r.byte_mode;
      end else if (s_axi_araddr == flash_query_pkg::addr_offset) begin
        next_r.rdata[19:0] = r.addr;
      end else if (s_axi_araddr == flash_query_pkg::wdata_offset) begin
        next_r.rdata[15:0] = r.wdata;
      end else if (s_axi_araddr == flash_query_pkg::rdata_offset) begin
        next_r.rdata[15:0] = r.rdata_flash;
      end else if (s_axi_araddr == flash_query_pkg::status_offset) begin
        next_r.rdata = status_word;
      end else begin
        next_r.rresp = flash_query_pkg::resp_slverr;
      end
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end

    // operation sequencer
    case (r.state)
      op_idle: begin
        if (go && wr_fire) begin
          next_r.state = op_wait_ready;
        end
      end
      op_wait_ready: begin
        // no entry while busy: wait for the ready pin first
        if (r.ready_sync) begin
          next_r.state = op_run;
          next_r.cyc_start = 1'b1;
        end
      end
      op_run: begin
        if (cyc_done) begin
          next_r.state = op_idle;
          if (r.op == flash_query_pkg::op_enter_query) begin
            next_r.in_query = 1'b1;
            next_r.sig_seen = 3'h0;
          end else if (r.op == flash_query_pkg::op_exit_query) begin
            // leave query: only after the reset command
            next_r.in_query = 1'b0;
            next_r.sig_seen = 3'h0;
          end else if (r.op == flash_query_pkg::op_read) begin
            // data pins beyond the low byte float in byte mode
            next_r.rdata_flash = r.byte_mode ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
            // signature check: Q, R, Y at 10h-12h
            if (r.in_query) begin
              if (r.addr == flash_query_pkg::sig_addr_q) begin
                next_r.sig_seen[0] = (cyc_rdata[7:0] == flash_query_pkg::sig_char_q[7:0]);
              end else if (r.addr == flash_query_pkg::sig_addr_r) begin
                next_r.sig_seen[1] = (cyc_rdata[7:0] == flash_query_pkg::sig_char_r[7:0]);
              end else if (r.addr == flash_query_pkg::sig_addr_y) begin
                next_r.sig_seen[2] = (cyc_rdata[7:0] == flash_query_pkg::sig_char_y[7:0]);
              end
            end
          end
        end
      end
      default: next_r.state = op_idle;
    endcase

    // a go while an operation runs is dropped and flagged
    if (go && wr_fire && r.state != op_idle) begin
      next_r.refused = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r.aw_held <= 1'b0;
      r.aw_addr <= 8'h00;
      r.w_held <= 1'b0;
      r.w_data <= 32'h00000000;
      r.w_strb <= 4'h0;
      r.bvalid <= 1'b0;
      r.bresp <= 2'h0;
      r.rvalid <= 1'b0;
      r.rresp <= 2'h0;
      r.rdata <= 32'h00000000;
      r.op <= flash_query_pkg::op_enter_query;
      r.byte_mode <= 1'b0;
      r.addr <= flash_query_pkg::addr_reset;
      r.wdata <= flash_query_pkg::wdata_reset;
      r.rdata_flash <= 16'h0000;
      r.in_query <= 1'b0;
      r.sig_seen <= 3'h0;
      r.refused <= 1'b0;
      r.state <= op_idle;
      r.cyc_start <= 1'b0;
      r.ready_meta <= 1'b0;
      r.ready_sync <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  flash_bus_cycle u_cycle (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .start         (r.cyc_start),
    .is_write      (cyc_write),
    .addr          (cyc_addr),
    .wdata         (cyc_wdata),
    .done          (cyc_done),
    .rdata         (cyc_rdata),
    .flash_addr    (flash_addr),
    .flash_ce_n    (flash_ce_n),
    .flash_we_n    (flash_we_n),
    .flash_oe_n    (flash_oe_n),
    .flash_dq_out  (flash_dq_out),
    .flash_dq_oe_n (flash_dq_oe_n),
    .flash_dq_in   (flash_dq_in)
  );

  assign s_axi_awready   = !r.aw_held;
  assign s_axi_wready    = !r.w_held;
  assign s_axi_bvalid    = r.bvalid;
  assign s_axi_bresp     = r.bresp;
  assign s_axi_arready   = !r.rvalid;
  assign s_axi_rvalid    = r.rvalid;
  assign s_axi_rresp     = r.rresp;
  assign s_axi_rdata     = r.rdata;
  assign flash_word_mode = !r.byte_mode;

endmodule : flash_query_host

// file: rtl/flash_query_pkg.sv
// constants for the flash query-mode host controller
package flash_query_pkg;

  // register word offsets (byte addresses on the register bus)
  localparam logic [7:0] ctrl_offset   = 8'h00;
  localparam logic [7:0] addr_offset   = 8'h04;
  localparam logic [7:0] wdata_offset  = 8'h08;
  localparam logic [7:0] rdata_offset  = 8'h0c;
  localparam logic [7:0] status_offset = 8'h10;

  // control register fields
  localparam int ctrl_go_bit       = 0;
  localparam int ctrl_op_lsb       = 1;
  localparam int ctrl_byte_mode_bit = 3;
  localparam logic [1:0] op_enter_query = 2'h0;
  localparam logic [1:0] op_exit_query  = 2'h1;
  localparam logic [1:0] op_read        = 2'h2;
  localparam logic [1:0] op_write       = 2'h3;

  // status register fields
  localparam int status_busy_bit    = 0;
  localparam int status_query_bit   = 1;
  localparam int status_sig_bit     = 2;
  localparam int status_refused_bit = 3;
  localparam int status_ready_bit   = 4;

  // reset values
  localparam logic [19:0] addr_reset  = 20'h00000;
  localparam logic [15:0] wdata_reset = 16'h0000;

  // flash command and table values
  localparam logic [15:0] query_cmd        = 16'h0098;
  localparam logic [20:0] query_word_addr  = 21'h000055;
  localparam logic [20:0] query_byte_addr  = 21'h0000aa;
  localparam logic [15:0] reset_cmd_default = 16'h00f0;
  localparam logic [19:0] sig_addr_q = 20'h00010;
  localparam logic [19:0] sig_addr_r = 20'h00011;
  localparam logic [19:0] sig_addr_y = 20'h00012;
  localparam logic [15:0] sig_char_q = 16'h0051;
  localparam logic [15:0] sig_char_r = 16'h0052;
  localparam logic [15:0] sig_char_y = 16'h0059;

  // bus answers
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // timing
  localparam int clk_period_ns = 10;
  localparam int t_setup_ns    = 10;
  localparam int t_strobe_ns   = 40;
  localparam int t_hold_ns     = 10;
  localparam int t_read_ns     = 80;
  localparam int sync_stages   = 2;
  localparam logic [3:0] setup_cycles  = 4'((t_setup_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [3:0] strobe_cycles = 4'((t_strobe_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [3:0] hold_cycles   = 4'((t_hold_ns + clk_period_ns - 1) / clk_period_ns);
  localparam logic [3:0] read_cycles   =
    4'((t_read_ns + clk_period_ns - 1) / clk_period_ns + sync_stages);

endpackage : flash_query_pkg

// file: testbench/flash_query_host_assertions.sv
// port assertions for the flash query host controller
`timescale 1ns/10ps
module flash_query_host_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [20:0] flash_addr,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n,
  input wire logic        flash_word_mode,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe_n
);
  default clocking dc @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bus_idle_a: assert property ($rose(aresetn) |-> flash_ce_n && flash_we_n && flash_oe_n
    && flash_dq_oe_n) else $error("strobes not idle after reset");
  strobe_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n[*4] ##1 flash_we_n)
    else $error("write strobe width wrong");
  write_framing_a: assert property (!flash_we_n |-> !flash_ce_n && flash_oe_n
    && !flash_dq_oe_n) else $error("write strobe outside select");
  addr_held_a: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved while selected");
  data_held_a: assert property (!flash_we_n |-> $stable(flash_dq_out))
    else $error("data moved under write strobe");
  we_first_a: assert property ($rose(flash_we_n) |-> !flash_ce_n ##1 flash_ce_n)
    else $error("select rose before write strobe");
  query_addr_a: assert property (!flash_we_n && flash_dq_out == 16'h0098
    |-> flash_addr == (flash_word_mode ? 21'h000055 : 21'h0000aa))
    else $error("query command at wrong address");
  read_strobe_a: assert property ($fell(flash_oe_n)
    |-> (!flash_oe_n && !flash_ce_n && flash_dq_oe_n)[*8] ##1 !flash_oe_n[*2])
    else $error("read strobe too short or contended");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  resp_held_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");

  cover property ($fell(flash_we_n) && flash_dq_out == 16'h0098);
  cover property ($fell(flash_oe_n) && !flash_word_mode);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : flash_query_host_checker

bind flash_query_host flash_query_host_checker chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .flash_addr, .flash_ce_n, .flash_we_n,
  .flash_oe_n, .flash_word_mode, .flash_dq_out, .flash_dq_oe_n);

// file: testbench/flash_query_model.sv
// behavioural flash device answering query-mode reads
`timescale 1ns/10ps
module flash_query_model #(
  parameter logic [15:0] cmd_set_id  = 16'h0007,  // arbitrary
  parameter logic [15:0] bank2_count = 16'h0012,
  parameter logic [15:0] boot_flag   = 16'h0003,
  parameter int          access_ns   = 70
) (
  input  wire logic [20:0] flash_addr,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_word_mode,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        embedded_busy,
  output logic [15:0]      flash_dq_in,
  output logic             flash_ready
);
  logic [20:0] cmd_addr;
  logic        qry = 1'b0;
  logic [15:0] held = 16'h0000;
  logic [7:0]  idx;
  logic [15:0] word;
  logic        strobe_n;
  assign strobe_n = flash_ce_n | flash_we_n;
  assign flash_ready = !embedded_busy;
  always @(negedge strobe_n) cmd_addr = flash_addr;
  always @(posedge strobe_n) begin
    if (flash_dq_out == 16'h0098 && !embedded_busy
        && cmd_addr == (flash_word_mode ? 21'h000055 : 21'h0000aa))
      qry = 1'b1;
    else if (flash_dq_out[7:0] == 8'hf0)
      qry = 1'b0;
  end
  assign idx = flash_word_mode ? flash_addr[7:0] : flash_addr[8:1];
  always_comb begin
    case (idx)
      8'h10: word = 16'h0051;
      8'h11: word = 16'h0052;
      8'h12: word = 16'h0059;
      8'h13: word = cmd_set_id;
      8'h15: word = 16'h0040;
      8'h1b: word = 16'h0027;
      8'h1c: word = 16'h0036;
      8'h1f: word = 16'h0004;
      8'h21: word = 16'h000a;
      8'h23: word = 16'h0005;
      8'h25: word = 16'h0004;
      8'h27: word = 16'h0016;
      8'h2c: word = 16'h0002;
      8'h2d: word = 16'h0007;
      8'h2f: word = 16'h0020;
      8'h31: word = 16'h003e;
      8'h34: word = 16'h0001;
      8'h40: word = 16'h0050;
      8'h41: word = 16'h0052;
      8'h42: word = 16'h0049;
      8'h43: word = 16'h0031;
      8'h44: word = 16'h0033;
      8'h45: word = 16'h0001;
      8'h46: word = 16'h0002;
      8'h47: word = 16'h0001;
      8'h48: word = 16'h0001;
      8'h49: word = 16'h0004;
      8'h4a: word = bank2_count;
      8'h4d: word = 16'h0085;
      8'h4e: word = 16'h0095;
      8'h4f: word = boot_flag;
      default: word = 16'h0000;
    endcase
    if (!qry)
      word = 16'hffff;
  end
  // released bus shows the inverse so a stale sample cannot pass
  always @(posedge flash_oe_n) held <= ~word;
  assign #(access_ns) flash_dq_in = (!flash_ce_n && !flash_oe_n) ? word : held;
endmodule : flash_query_model

// file: testbench/tb_flash_query_host.sv
// self-checking bench for the flash query host controller
`timescale 1ns/10ps
`define check(what, exp, got) \
  begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("BAD %s exp %h got %h", what, exp, got); end end
module tb_flash_query_host;
  localparam logic [15:0] cmd_set_id  = 16'h0007;  // arbitrary value
  localparam logic [15:0] bank2_count = 16'h0012;
  localparam logic [15:0] boot_flag   = 16'h0003;
  localparam logic [23:0] exp_tbl [40] = '{24'h100051, 24'h110052, 24'h120059,
    {8'h13, cmd_set_id}, 24'h150040, 24'h160000, 24'h170000, 24'h1a0000, 24'h1b0027,
    24'h1c0036, 24'h1d0000, 24'h1f0004, 24'h200000, 24'h21000a, 24'h230005, 24'h250004,
    24'h260000, 24'h270016, 24'h2a0000, 24'h2c0002, 24'h2d0007, 24'h2f0020, 24'h31003e,
    24'h340001, 24'h350000, 24'h400050, 24'h420049, 24'h430031, 24'h440033, 24'h450001,
    24'h460002, 24'h470001, 24'h480001, 24'h490004, {8'h4a, bank2_count}, 24'h4b0000,
    24'h4c0000, 24'h4d0085, 24'h4e0095, {8'h4f, boot_flag}};
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        embedded_busy = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [20:0] flash_addr;
  logic        flash_ce_n, flash_we_n, flash_oe_n, flash_word_mode, flash_dq_oe_n, flash_ready;
  logic [15:0] flash_dq_out, flash_dq_in;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cycles   = 0;

  always #5 aclk = ~aclk;

  flash_query_host uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n,
    .flash_word_mode, .flash_dq_out, .flash_dq_oe_n, .flash_dq_in, .flash_ready);
  flash_query_model #(.cmd_set_id(cmd_set_id), .bank2_count(bank2_count), .boot_flag(boot_flag))
    dev (.flash_addr, .flash_ce_n, .flash_we_n, .flash_oe_n, .flash_word_mode, .flash_dq_out,
    .embedded_busy, .flash_dq_in, .flash_ready);

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    `check("rresp", 2'h0, s_axi_rresp)
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic wait_idle();
    do axi_rd(flash_query_pkg::status_offset, d);
    while (d[flash_query_pkg::status_busy_bit] !== 1'b0);
  endtask : wait_idle

  // go is posted, so a second one can be refused
  task automatic go(input logic [1:0] op, input logic bm, input logic wait_done);
    axi_wr(flash_query_pkg::ctrl_offset, {28'h0, bm, op, 1'b1}, r);
    if (wait_done)
      wait_idle();
  endtask : go

  task automatic rd_word(input logic [19:0] a, input logic bm);
    axi_wr(flash_query_pkg::addr_offset, {12'h0, a}, r);
    go(flash_query_pkg::op_read, bm, 1'b1);
    axi_rd(flash_query_pkg::rdata_offset, d);
  endtask : rd_word

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(flash_query_pkg::status_offset, d);
    `check("status", 32'h10, d)
    go(flash_query_pkg::op_enter_query, 1'b0, 1'b1);
    `check("entered", 1'b1, dev.qry)
    foreach (exp_tbl[i]) begin
      rd_word({12'h0, exp_tbl[i][23:16]}, 1'b0);
      `check("table word", {16'h0, exp_tbl[i][15:0]}, d)
    end
    axi_rd(flash_query_pkg::status_offset, d);
    `check("signature", 3'b110, d[2:0])
    go(flash_query_pkg::op_exit_query, 1'b0, 1'b1);
    rd_word(20'h00010, 1'b0);
    `check("array word", 32'hffff, d)
    go(flash_query_pkg::op_enter_query, 1'b1, 1'b1);
    rd_word(20'h0001c, 1'b1);
    `check("byte read", 32'h36, d)
    rd_word(20'h00012, 1'b1);
    `check("byte read", 32'h59, d)
    axi_wr(flash_query_pkg::wdata_offset, 32'hf0, r);
    go(flash_query_pkg::op_write, 1'b0, 1'b1);
    `check("left query", 1'b0, dev.qry)
    embedded_busy <= 1'b1;
    repeat (4) @(posedge aclk);
    go(flash_query_pkg::op_enter_query, 1'b0, 1'b0);
    go(flash_query_pkg::op_enter_query, 1'b0, 1'b0);
    axi_rd(flash_query_pkg::status_offset, d);
    `check("held off", 3'b011, {d[4], d[3], d[0]})
    `check("no entry", 1'b0, dev.qry)
    embedded_busy <= 1'b0;
    wait_idle();
    `check("late entry", 1'b1, dev.qry)
    axi_wr(flash_query_pkg::status_offset, 32'h8, r);
    axi_rd(flash_query_pkg::status_offset, d);
    `check("refused", 1'b0, d[3])
    go(flash_query_pkg::op_exit_query, 1'b0, 1'b1);
    `check("exit", 1'b0, dev.qry)
    axi_wr(8'h40, 32'h0, r);
    `check("unmapped", 2'h2, r)
    complete_run();
  end
endmodule : tb_flash_query_host
